// file: verilog/hdcr_pkg.sv
// Package for the host hardware and DMA configuration register bank.
// Assumes one 200 MHz controller clock and a command-then-data register port.
package hdcr_pkg;

   // =========================================================
   // Command codes
   localparam logic [7:0] CMD_HW_RD = 8'h20;
   localparam logic [7:0] CMD_HW_WR = 8'hA0;
   localparam logic [7:0] CMD_DMA_RD = 8'h21;
   localparam logic [7:0] CMD_DMA_WR = 8'hA1;

   // =========================================================
   // Hardware configuration fields
   localparam int HW_IRQ_GATE_BIT = 0;
   localparam int HW_IRQ_STYLE_BIT = 1;
   localparam int HW_IRQ_LEVEL_BIT = 2;
   localparam int HW_BUS_LSB = 3;
   localparam int HW_BUS_MSB = 4;
   localparam int HW_DREQ_LEVEL_BIT = 5;
   localparam int HW_DACK_LEVEL_BIT = 6;
   localparam int HW_EOT_LEVEL_BIT = 7;
   localparam int HW_ACK_MODE_BIT = 8;
   localparam int HW_OC_SEL_BIT = 10;
   localparam int HW_CLK_KEEP_BIT = 11;
   localparam int HW_PULLDOWN_BIT = 12;
   localparam logic [15:0] HW_WR_MASK = 16'h1DA7;
   localparam logic [15:0] HW_RESET = 16'h0020;
   localparam logic [1:0] BUS_SIZE_16 = 2'h1;

   // =========================================================
   // DMA configuration fields
   localparam int DMA_DIR_BIT = 0;
   localparam int DMA_BUF_BIT = 1;
   localparam int DMA_CNT_BIT = 2;
   localparam int DMA_EN_BIT = 4;
   localparam int DMA_BURST_LSB = 5;
   localparam int DMA_BURST_MSB = 6;
   localparam logic [15:0] DMA_WR_MASK = 16'h0077;
   localparam logic [15:0] DMA_RESET = 16'h0000;

   // =========================================================
   // Timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int IRQ_PULSE_NS = 10;
   localparam int IRQ_PULSE_CYCLES =
      ((IRQ_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1) ? 1 :
      (IRQ_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : hdcr_pkg

// file: verilog/hdcr_irq_pin.sv
// Interrupt pin driver: level or pulse signalling with selectable polarity.
// Assumes the pending input is already gated and comes from a flip-flop.
`timescale 1ns/100ps
module hdcr_irq_pin #(
   parameter int PULSE_CYCLES = hdcr_pkg::IRQ_PULSE_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic pending_i,
   input wire logic edge_style_i,
   input wire logic active_high_i,
   output logic pin_o
);
   logic pend_prev_q;
   logic [7:0] pulse_cnt_q;
   logic asserted;

   // =========================================================
   // Edge style: fixed-width pulse on each new pending event
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pend_prev_q <= 1'b0;
         pulse_cnt_q <= 8'h00;
      end else if (ce_i) begin
         pend_prev_q <= pending_i;
         if (edge_style_i && pending_i && !pend_prev_q) begin
            pulse_cnt_q <= 8'(PULSE_CYCLES);
         end else if (pulse_cnt_q != 8'h00) begin
            pulse_cnt_q <= pulse_cnt_q - 8'h01;
         end
      end
   end

   assign asserted = edge_style_i ? (pulse_cnt_q != 8'h00) : pending_i;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pin_o <= 1'b1;
      end else if (ce_i) begin
         pin_o <= asserted ~^ active_high_i;
      end
   end

   chk_pulse_bounded: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      edge_style_i && ce_i |-> pulse_cnt_q <= 8'(PULSE_CYCLES))
      else $error("irq pulse counter above its width");

endmodule : hdcr_irq_pin

// file: verilog/hdcr_regs.sv
// Host hardware and DMA configuration registers with pin polarity logic.
// Assumes command/data strobes synchronous to sys_clk_i, one cycle wide.
//
// Contract
// - Interrupt pin asserts only with master gate and a matching source enable.
// - Bus size field always reads 01; writes never change it.
// - Code 20h reads and A0h writes the hardware configuration register.
// - Bit 12 picks external or built-in downstream pull-downs, reset 0.
// - Bit 11 keeps the clock running in suspend when set, reset 0.
// - Bit 10 picks digital external or on-chip analog overcurrent sensing.
// - Bit 8 is acknowledge mode; 0 means acknowledge qualifies read/write strobes.
// - Bits 7,6,5,2 set pin levels; bit 6 stays active low.
// - Bit 1 picks level or pulsed interrupt signalling, reset level.
// - DMA register holds burst, enable, counter, buffer, direction fields; reset 0.
// - Code 21h reads and A1h writes the DMA configuration register.
// - Burst field gives 1, 4 or 8 beats; 11 reserved.
// - DMA enable starts or stops DMA and clears itself on completion.
// - With counter used, request needs a non-zero byte count; else transfer-end ends.
// - Buffer bit picks isochronous or acknowledged list; direction picks read or write.
`timescale 1ns/100ps
module hdcr_regs (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Register port: command phase then data phase
   input wire logic cmd_stb_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic wr_stb_i,
   input wire logic [15:0] wr_data_i,
   input wire logic rd_stb_i,
   output logic [15:0] rd_data_o,
   output logic rd_valid_o,
   // Interrupt sources from the status logic
   input wire logic [15:0] irq_status_i,
   input wire logic [15:0] host_irq_source_enables_i,
   output logic host_irq_pin_o,
   // DMA handshake
   input wire logic dma_req_int_i,
   input wire logic byte_count_nonzero_i,
   input wire logic dma_done_i,
   input wire logic host_dma_ack_pin_i,
   input wire logic transfer_end_input_i,
   output logic host_dma_request_pin_o,
   output logic dma_ack_active_o,
   output logic transfer_end_seen_o,
   // Configuration outputs
   output logic pulldown_source_select_o,
   output logic suspend_clock_keep_o,
   output logic overcurrent_sense_select_o,
   output logic dma_ack_mode_o,
   output logic [1:0] burst_size_field_o,
   output logic [3:0] burst_beats_o,
   output logic dma_enable_o,
   output logic byte_counter_use_o,
   output logic list_buffer_select_o,
   output logic transfer_direction_o
);
   logic [15:0] hw_q;
   logic [15:0] dma_q;
   logic [7:0] cmd_q;
   logic irq_pend_q;
   logic dma_end_evt;
   logic [15:0] hw_view;

   // =========================================================
   // Burst field to beats; reserved code falls back to single cycle
   function automatic logic [3:0] burst_beats(input logic [1:0] f);
      logic [3:0] b;
      b = 4'h1;
      unique case (f)
         2'h0: b = 4'h1;
         2'h1: b = 4'h4;
         2'h2: b = 4'h8;
         2'h3: b = 4'h1;
      endcase
      return b;
   endfunction : burst_beats

   // Bus size is not stored, so no write can disturb it
   assign hw_view = (hw_q & hdcr_pkg::HW_WR_MASK) |
      {11'h000, hdcr_pkg::BUS_SIZE_16, 3'h0};

   // =========================================================
   // Command latch
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         cmd_q <= 8'h00;
      end else if (ce_i && cmd_stb_i) begin
         cmd_q <= cmd_code_i;
      end
   end

   // =========================================================
   // Hardware configuration register
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         hw_q <= hdcr_pkg::HW_RESET;
      end else if (ce_i && wr_stb_i && cmd_q == hdcr_pkg::CMD_HW_WR) begin
         // Reserved bits and the fixed active-low acknowledge level are masked
         hw_q <= wr_data_i & hdcr_pkg::HW_WR_MASK;
      end
   end

   // =========================================================
   // DMA configuration register; a write in the done cycle wins so a new
   // transfer started right at completion is not cancelled
   assign dma_end_evt = dma_done_i ||
      (!dma_q[hdcr_pkg::DMA_CNT_BIT] && transfer_end_seen_o);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         dma_q <= hdcr_pkg::DMA_RESET;
      end else if (ce_i) begin
         if (wr_stb_i && cmd_q == hdcr_pkg::CMD_DMA_WR) begin
            dma_q <= wr_data_i & hdcr_pkg::DMA_WR_MASK;
         end else if (dma_end_evt) begin
            dma_q[hdcr_pkg::DMA_EN_BIT] <= 1'b0;
         end
      end
   end

   // =========================================================
   // Read path: data registered one cycle after the read strobe
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rd_data_o <= 16'h0000;
         rd_valid_o <= 1'b0;
      end else if (ce_i) begin
         rd_valid_o <= rd_stb_i;
         if (rd_stb_i) begin
            if (cmd_q == hdcr_pkg::CMD_HW_RD) begin
               rd_data_o <= hw_view;
            end else if (cmd_q == hdcr_pkg::CMD_DMA_RD) begin
               rd_data_o <= dma_q & hdcr_pkg::DMA_WR_MASK;
            end else begin
               rd_data_o <= 16'h0000;
            end
         end
      end
   end

   // =========================================================
   // Pin logic
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         irq_pend_q <= 1'b0;
         host_dma_request_pin_o <= 1'b0;
         dma_ack_active_o <= 1'b0;
         transfer_end_seen_o <= 1'b0;
      end else if (ce_i) begin
         irq_pend_q <= hw_q[hdcr_pkg::HW_IRQ_GATE_BIT] &&
            |(irq_status_i & host_irq_source_enables_i);
         host_dma_request_pin_o <= (dma_req_int_i && dma_q[hdcr_pkg::DMA_EN_BIT] &&
            (!dma_q[hdcr_pkg::DMA_CNT_BIT] || byte_count_nonzero_i))
            ~^ hw_q[hdcr_pkg::HW_DREQ_LEVEL_BIT];
         // Acknowledge is only ever active low; mode 1 is treated as normal
         dma_ack_active_o <= !host_dma_ack_pin_i;
         transfer_end_seen_o <= transfer_end_input_i ~^
            hw_q[hdcr_pkg::HW_EOT_LEVEL_BIT];
      end
   end

   hdcr_irq_pin #(
      .PULSE_CYCLES(hdcr_pkg::IRQ_PULSE_CYCLES)
   ) u_irq_pin (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .pending_i(irq_pend_q),
      .edge_style_i(hw_q[hdcr_pkg::HW_IRQ_STYLE_BIT]),
      .active_high_i(hw_q[hdcr_pkg::HW_IRQ_LEVEL_BIT]),
      .pin_o(host_irq_pin_o)
   );

   // =========================================================
   // Configuration outputs straight from the register flops; burst_beats_o is decoded and registered one cycle later
   assign pulldown_source_select_o = hw_q[hdcr_pkg::HW_PULLDOWN_BIT];
   assign suspend_clock_keep_o = hw_q[hdcr_pkg::HW_CLK_KEEP_BIT];
   assign overcurrent_sense_select_o = hw_q[hdcr_pkg::HW_OC_SEL_BIT];
   assign dma_ack_mode_o = hw_q[hdcr_pkg::HW_ACK_MODE_BIT];
   assign burst_size_field_o = dma_q[hdcr_pkg::DMA_BURST_MSB:hdcr_pkg::DMA_BURST_LSB];
   assign dma_enable_o = dma_q[hdcr_pkg::DMA_EN_BIT];
   assign byte_counter_use_o = dma_q[hdcr_pkg::DMA_CNT_BIT];
   assign list_buffer_select_o = dma_q[hdcr_pkg::DMA_BUF_BIT];
   assign transfer_direction_o = dma_q[hdcr_pkg::DMA_DIR_BIT];

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         burst_beats_o <= 4'h1;
      end else if (ce_i) begin
         burst_beats_o <= burst_beats(dma_q[hdcr_pkg::DMA_BURST_MSB:hdcr_pkg::DMA_BURST_LSB]);
      end
   end

   // =========================================================
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   chk_irq_gate_off: assert property (
      ce_i && !hw_q[hdcr_pkg::HW_IRQ_GATE_BIT] |=> !irq_pend_q)
      else $error("interrupt pending without master gate");

   chk_bus_size_read: assert property (
      ce_i && rd_stb_i && cmd_q == hdcr_pkg::CMD_HW_RD |=> rd_valid_o && rd_data_o[4:3] == 2'h1)
      else $error("bus size field did not read 01");

   chk_hw_write_decode: assert property (
      ce_i && wr_stb_i && cmd_q == hdcr_pkg::CMD_HW_WR
      |=> hw_q == ($past(wr_data_i) & hdcr_pkg::HW_WR_MASK))
      else $error("hardware config write not taken");

   chk_dma_write_decode: assert property (
      ce_i && wr_stb_i && cmd_q == hdcr_pkg::CMD_DMA_WR
      |=> dma_q == ($past(wr_data_i) & hdcr_pkg::DMA_WR_MASK))
      else $error("dma config write not taken");

   chk_reserved_zero: assert property (
      (hw_q & ~hdcr_pkg::HW_WR_MASK) == 16'h0000 && (dma_q & ~hdcr_pkg::DMA_WR_MASK) == 16'h0000)
      else $error("reserved bit held a one");

   chk_dma_auto_clear: assert property (
      ce_i && dma_done_i && !(wr_stb_i && cmd_q == hdcr_pkg::CMD_DMA_WR) |=> !dma_enable_o)
      else $error("dma enable not cleared on completion");

   chk_req_needs_count: assert property (
      ce_i && byte_counter_use_o && !byte_count_nonzero_i
      |=> host_dma_request_pin_o == !$past(hw_q[hdcr_pkg::HW_DREQ_LEVEL_BIT]))
      else $error("dma request raised with zero byte count");

   chk_ack_low_only: assert property (
      ce_i |=> dma_ack_active_o == !$past(host_dma_ack_pin_i) && !hw_q[hdcr_pkg::HW_DACK_LEVEL_BIT])
      else $error("acknowledge not taken active low");

   chk_burst_beats: assert property (
      ce_i && burst_size_field_o == 2'h2 |=> burst_beats_o == 4'h8)
      else $error("8-beat burst not decoded");

   cov_hw_write: cover property (ce_i && wr_stb_i && cmd_q == hdcr_pkg::CMD_HW_WR);
   cov_dma_done: cover property (ce_i && dma_enable_o && dma_done_i);
   cov_irq_raise: cover property (ce_i && irq_pend_q && hw_q[hdcr_pkg::HW_IRQ_STYLE_BIT]);

endmodule : hdcr_regs

// file: dv/hdcr_dma_partner.sv
// Far-side model of the DMA pins: acknowledges requests, drives transfer-end.
// Assumes the register bank's request pin and one shared clock.
`timescale 1ns/100ps
module hdcr_dma_partner (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic req_pin_i,
   input wire logic req_high_i,
   input wire logic eot_high_i,
   input wire logic slow_i,
   input wire logic end_i,
   output logic ack_n_o,
   output logic eot_o
);
   logic ack_q;
   logic ack_d1_q;
   // ========
   // Acknowledge
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ack_q <= 1'b0;
         ack_d1_q <= 1'b0;
      end else begin
         ack_d1_q <= (req_pin_i == req_high_i);
         ack_q <= slow_i ? ack_d1_q : (req_pin_i == req_high_i);
      end
   end
   // Only an active-low acknowledge is legal on this pin
   assign ack_n_o = ~ack_q;
   // Drives transfer-end at its active level while end_i is set
   assign eot_o = end_i ? eot_high_i : ~eot_high_i;
endmodule : hdcr_dma_partner

// file: dv/hdcr_regs_tb.sv
// Self-checking bench for the hardware and DMA configuration registers.
// Assumes the DMA partner model on the pins and a 200 MHz clock.
`timescale 1ns/100ps
module hdcr_regs_tb;
   logic sys_clk_i = 0, sys_rst_i = 1, ce_i = 1, cmd_stb_i = 0, wr_stb_i = 0, rd_stb_i = 0;
   logic [7:0] cmd_code_i = 0;
   logic [15:0] wr_data_i = 0, irq_status_i = 0, host_irq_source_enables_i = 0, rd_data_o;
   logic dma_req_int_i = 0, byte_count_nonzero_i = 0, dma_done_i = 0, slow = 0, end_req = 0;
   logic host_dma_ack_pin_i, transfer_end_input_i, rd_valid_o, host_irq_pin_o;
   logic host_dma_request_pin_o, dma_ack_active_o, transfer_end_seen_o;
   logic pulldown_source_select_o, suspend_clock_keep_o, overcurrent_sense_select_o;
   logic dma_ack_mode_o, dma_enable_o, byte_counter_use_o, list_buffer_select_o;
   logic transfer_direction_o;
   logic [1:0] burst_size_field_o;
   logic [3:0] burst_beats_o;
   int errors = 0, compares = 0, n;
   wire [15:0] hw_out = {12'h000, pulldown_source_select_o, suspend_clock_keep_o,
      overcurrent_sense_select_o, dma_ack_mode_o};
   wire [15:0] dma_out = {10'h000, burst_size_field_o, dma_enable_o, byte_counter_use_o,
      list_buffer_select_o, transfer_direction_o};

   hdcr_regs uut (.*);
   hdcr_dma_partner partner (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .req_pin_i(host_dma_request_pin_o), .req_high_i(1'b1), .eot_high_i(1'b0),
      .slow_i(slow), .end_i(end_req), .ack_n_o(host_dma_ack_pin_i),
      .eot_o(transfer_end_input_i));

   always #2.5 sys_clk_i = ~sys_clk_i;

   // ========
   // Port tasks
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk_i);
      #1;
   endtask : cyc
   task automatic check(input string s, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask : check
   task automatic cmd(input logic [7:0] c);
      cmd_code_i = c;
      cmd_stb_i = 1;
      cyc(1);
      cmd_stb_i = 0;
   endtask : cmd
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      cmd(c);
      wr_stb_i = 1;
      wr_data_i = d;
      cyc(1);
      wr_stb_i = 0;
      cyc(1);
   endtask : wr
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      cmd(c);
      rd_stb_i = 1;
      cyc(1);
      rd_stb_i = 0;
      check("rd_valid", 16'h0001, {15'h0000, rd_valid_o});
      check("rd_data", e, rd_data_o);
   endtask : rd
   task automatic results();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results

   // ========
   // Tests
   initial begin
      cyc(5);
      sys_rst_i = 0;
      rd(8'h20, 16'h0028);
      rd(8'h21, 16'h0000);
      check("irq_pin", 16'h0001, {15'h0000, host_irq_pin_o});
      check("req_pin", 16'h0000, {15'h0000, host_dma_request_pin_o});
      wr(8'hA0, 16'hFFFF);
      rd(8'h20, 16'h1DAF);
      check("hw_out", 16'h000F, hw_out);
      wr(8'hA0, 16'h0000);
      rd(8'h20, 16'h0008);
      check("hw_out", 16'h0000, hw_out);
      check("req_idle", 16'h0001, {15'h0000, host_dma_request_pin_o});
      wr(8'hA0, 16'h0020);
      wr(8'hA1, 16'hFFFF);
      rd(8'h21, 16'h0077);
      check("dma_out", 16'h003F, dma_out);
      for (n = 0; n < 4; n++) begin
         wr(8'hA1, 16'(n) << 5);
         check("beats", (n % 3 == 0) ? 16'h0001 : 16'(n * 4), {12'h000, burst_beats_o});
      end
      wr(8'hA1, 16'h0002);
      check("dma_out", 16'h0002, dma_out);
      wr(8'h22, 16'hFFFF);
      rd(8'h22, 16'h0000);
      ce_i = 0;
      wr(8'hA1, 16'h0011);
      ce_i = 1;
      rd(8'h21, 16'h0002);
      dma_req_int_i = 1;
      wr(8'hA1, 16'h0010);
      check("req_pin", 16'h0001, {15'h0000, host_dma_request_pin_o});
      cyc(2);
      check("ack_active", 16'h0001, {15'h0000, dma_ack_active_o});
      dma_done_i = 1;
      cyc(1);
      dma_done_i = 0;
      cyc(1);
      check("dma_out", 16'h0000, dma_out);
      check("req_pin", 16'h0000, {15'h0000, host_dma_request_pin_o});
      slow = 1;
      wr(8'hA1, 16'h0014);
      cyc(2);
      check("req_pin", 16'h0000, {15'h0000, host_dma_request_pin_o});
      byte_count_nonzero_i = 1;
      cyc(1);
      check("req_pin", 16'h0001, {15'h0000, host_dma_request_pin_o});
      cyc(3);
      check("ack_active", 16'h0001, {15'h0000, dma_ack_active_o});
      byte_count_nonzero_i = 0;
      wr(8'hA1, 16'h0010);
      end_req = 1;
      cyc(3);
      check("eot_seen", 16'h0001, {15'h0000, transfer_end_seen_o});
      check("dma_out", 16'h0000, dma_out);
      end_req = 0;
      dma_req_int_i = 0;
      wr(8'hA0, 16'h0021);
      irq_status_i = 16'h0001;
      host_irq_source_enables_i = 16'h0002;
      cyc(3);
      check("irq_pin", 16'h0001, {15'h0000, host_irq_pin_o});
      host_irq_source_enables_i = 16'h0001;
      cyc(2);
      check("irq_pin", 16'h0000, {15'h0000, host_irq_pin_o});
      wr(8'hA0, 16'h0020);
      cyc(2);
      check("irq_pin", 16'h0001, {15'h0000, host_irq_pin_o});
      wr(8'hA0, 16'h0025);
      cyc(2);
      check("irq_pin", 16'h0001, {15'h0000, host_irq_pin_o});
      host_irq_source_enables_i = 16'h0000;
      wr(8'hA0, 16'h0023);
      host_irq_source_enables_i = 16'h0001;
      n = 0;
      repeat (8) begin
         cyc(1);
         n = n + int'(host_irq_pin_o === 1'b0);
      end
      check("pulse_len", 16'h0002, 16'(n));
      results();
   end

   // Watchdog: the tests need well under a thousand cycles
   initial begin
      #20000;
      errors++;
      results();
   end
endmodule : hdcr_regs_tb
